// ==== txc_regs.sv ====
// txc_regs: transmit configuration and memory allocation registers on AXI4-Lite
`timescale 1ns/1ns
// Function
// - writing one to bit 15 clears status FIFO pointers; bit self-clears.
// - writing one to bit 14 clears data FIFO pointers; bit self-clears.
// - with overrun-allow zero, transmission pauses while status FIFO is full.
// - with overrun-allow one, transmission continues despite full status FIFO.
// - status-full interrupt raised the same regardless of overrun-allow.
// - transmit enable set lets queued data go out; resets to zero.
// - transmit enable clears itself after stop requested and transmitter halted.
// - stop bit lets current frame finish then stops further frames.
// - stop bit self-clears once transmitter has actually stopped.
// - writes to stop bit ignored while it reads one.
// - bit 24 is read-only latched auto-crossover strap level.
// - size field bits 16-19 sets transmit allocation in 1KB steps, reset 5.
// - status FIFO takes fixed 512 bytes, data FIFO takes the rest.
// - data FIFO holds both command words and payload.
// - receive FIFOs get 16KB minus transmit allocation.
module txc_regs #(
    parameter int ADDR_W = txc_pkg::ADDR_W
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address channel
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    // write data channel
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // write response channel
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // read address channel
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    // read data channel
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // strap
    input wire logic auto_crossover_strap,
    // transmit engine
    input wire logic frame_active,
    input wire logic frame_start_req,
    input wire logic status_push,
    input wire logic status_pop,
    input wire logic data_push,
    input wire logic data_pop,
    output logic tx_go,
    output logic tx_running,
    output logic tx_status_full,
    output logic [ADDR_W:0] tx_data_bytes,
    output logic [ADDR_W:0] rx_bytes,
    output logic must_be_one_out,
    // interrupt
    output logic irq
);
    typedef enum logic [1:0] {TXC_IDLE, TXC_RUN, TXC_DRAIN} txc_state_t;
    localparam int IRQ_W_L = txc_pkg::IRQ_W;

    txc_state_t state;
    logic tx_status_flush;
    logic tx_data_flush;
    logic status_overrun_allow;
    logic tx_on;
    logic stop_tx;
    logic must_be_one;
    logic [3:0] tx_fifo_size;
    logic strap_q;
    logic strap_taken;
    logic [IRQ_W_L-1:0] irq_status;
    logic [IRQ_W_L-1:0] irq_mask;
    logic aw_have;
    logic [31:0] w_q;
    logic [3:0] ws_q;
    logic w_have;
    logic [7:0] aw_addr_q;
    logic do_write;
    logic do_read;
    logic [31:0] rd_val;
    logic sts_full;
    logic [ADDR_W-1:0] sts_level;
    logic [ADDR_W-1:0] dat_level;
    logic [ADDR_W:0] tx_total;
    logic [ADDR_W:0] sts_bytes;
    logic [ADDR_W:0] dat_bytes;
    logic [ADDR_W:0] rx_b;
    logic halted;
    logic stopped_evt;
    logic full_q;
    logic next_aw_have;
    logic next_w_have;
    logic next_bvalid;
    logic next_rvalid;

    function automatic logic byte_en(input logic [3:0] strb, input int bitpos);
        byte_en = strb[bitpos / 8];
    endfunction : byte_en

    // fifo pointers, status entries counted in dwords
    txc_ptr #(.W(ADDR_W)) u_sts (
        .aclk(aclk),
        .aresetn(aresetn),
        .flush(tx_status_flush),
        .push(status_push),
        .pop(status_pop),
        .capacity(ADDR_W'(sts_bytes >> 2)),
        .level(sts_level),
        .full(sts_full),
        .empty()
    );

    txc_ptr #(.W(ADDR_W)) u_dat (
        .aclk(aclk),
        .aresetn(aresetn),
        .flush(tx_data_flush),
        .push(data_push),
        .pop(data_pop),
        .capacity(ADDR_W'(dat_bytes >> 2)),
        .level(dat_level),
        .full(),
        .empty()
    );

    txc_alloc #(.W(ADDR_W)) u_alloc (
        .size_kb(tx_fifo_size),
        .tx_total(tx_total),
        .tx_status_bytes(sts_bytes),
        .tx_data_bytes(dat_bytes),
        .rx_bytes(rx_b)
    );

    // axi write: take address and data in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr_q <= 8'h00;
            w_q <= 32'h00000000;
            ws_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= txc_pkg::RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_have <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_have <= 1'b1;
                w_q <= wdata;
                ws_q <= wstrb;
            end
            if (do_write)
            begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                bvalid <= 1'b1;
                bresp <= known(aw_addr_q) ? txc_pkg::RESP_OKAY : txc_pkg::RESP_SLVERR;
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
        end
    end

    assign do_write = aw_have && w_have && !bvalid;
    assign next_bvalid = do_write || (bvalid && !bready);
    assign next_aw_have = !do_write && (aw_have || (awvalid && awready));
    assign next_w_have = !do_write && (w_have || (wvalid && wready));
    assign next_rvalid = do_read || (rvalid && !rready);

    // ready flags registered from the next state of what they guard
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b0;
            wready <= 1'b0;
            arready <= 1'b0;
        end
        else
        begin
            awready <= !next_aw_have && !next_bvalid;
            wready <= !next_w_have && !next_bvalid;
            arready <= !next_rvalid;
        end
    end

    function automatic logic known(input logic [7:0] a);
        known = (a == txc_pkg::TXCFG_OFFSET) || (a == txc_pkg::HWCFG_OFFSET) ||
            (a == txc_pkg::IRQ_STATUS_OFFSET) || (a == txc_pkg::IRQ_MASK_OFFSET);
    endfunction : known

    // axi read: one cycle answer
    assign do_read = arvalid && arready;

    always_comb
    begin
        rd_val = 32'h00000000;
        unique case (araddr)
            txc_pkg::TXCFG_OFFSET:
            begin
                rd_val[txc_pkg::SOA_BIT] = status_overrun_allow;
                rd_val[txc_pkg::TX_ON_BIT] = tx_on;
                rd_val[txc_pkg::STOP_TX_BIT] = stop_tx;
            end
            txc_pkg::HWCFG_OFFSET:
            begin
                rd_val[txc_pkg::STRAP_BIT] = strap_q;
                rd_val[txc_pkg::MBO_BIT] = must_be_one;
                rd_val[txc_pkg::SIZE_LSB +: txc_pkg::SIZE_W] = tx_fifo_size;
            end
            txc_pkg::IRQ_STATUS_OFFSET: rd_val[IRQ_W_L-1:0] = irq_status;
            txc_pkg::IRQ_MASK_OFFSET: rd_val[IRQ_W_L-1:0] = irq_mask;
            default: rd_val = 32'h00000000;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= txc_pkg::RESP_OKAY;
        end
        else if (do_read)
        begin
            rvalid <= 1'b1;
            rdata <= rd_val;
            rresp <= known(araddr) ? txc_pkg::RESP_OKAY : txc_pkg::RESP_SLVERR;
        end
        else if (rready)
            rvalid <= 1'b0;
    end

    // strap caught once after reset release
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            strap_q <= 1'b0;
            strap_taken <= 1'b0;
        end
        else if (!strap_taken)
        begin
            strap_q <= auto_crossover_strap;
            strap_taken <= 1'b1;
        end
    end

    logic wr_tx;
    logic wr_hw;
    assign wr_tx = do_write && (aw_addr_q == txc_pkg::TXCFG_OFFSET);
    assign wr_hw = do_write && (aw_addr_q == txc_pkg::HWCFG_OFFSET);

    // flush strobes: one cycle, then clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_status_flush <= 1'b0;
            tx_data_flush <= 1'b0;
        end
        else
        begin
            tx_status_flush <= wr_tx && byte_en(ws_q, txc_pkg::TXS_FLUSH_BIT)
                && w_q[txc_pkg::TXS_FLUSH_BIT];
            tx_data_flush <= wr_tx && byte_en(ws_q, txc_pkg::TXD_FLUSH_BIT)
                && w_q[txc_pkg::TXD_FLUSH_BIT];
        end
    end

    // transmit engine control
    assign halted = (state == TXC_IDLE) || ((state == TXC_DRAIN) && !frame_active);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            status_overrun_allow <= 1'b0;
            tx_on <= 1'b0;
            stop_tx <= 1'b0;
        end
        else
        begin
            if (wr_tx && byte_en(ws_q, txc_pkg::SOA_BIT))
            begin
                status_overrun_allow <= w_q[txc_pkg::SOA_BIT];
                tx_on <= w_q[txc_pkg::TX_ON_BIT];
                if (!stop_tx)
                    stop_tx <= w_q[txc_pkg::STOP_TX_BIT];
            end
            if (stopped_evt)
            begin
                stop_tx <= 1'b0;
                tx_on <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state <= TXC_IDLE;
        else
        begin
            unique case (state)
                TXC_IDLE:
                    if (tx_on && !stop_tx)
                        state <= TXC_RUN;
                TXC_RUN:
                    if (stop_tx || !tx_on)
                        state <= TXC_DRAIN;
                TXC_DRAIN:
                    if (!frame_active)
                        state <= TXC_IDLE;
            endcase
        end
    end

    // new frames start only while running, and only with status space or with overrun-allow set
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_go <= 1'b0;
            tx_running <= 1'b0;
            tx_status_full <= 1'b0;
            tx_data_bytes <= '0;
            rx_bytes <= '0;
            must_be_one_out <= 1'b0;
        end
        else
        begin
            tx_go <= frame_start_req && (state == TXC_RUN) && tx_on && !stop_tx
                && (status_overrun_allow || !sts_full);
            tx_running <= !halted;
            tx_status_full <= sts_full;
            tx_data_bytes <= dat_bytes;
            rx_bytes <= rx_b;
            must_be_one_out <= must_be_one;
        end
    end

    // hardware configuration fields
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            must_be_one <= 1'b0;
            tx_fifo_size <= txc_pkg::SIZE_RESET;
        end
        else if (wr_hw && byte_en(ws_q, txc_pkg::SIZE_LSB))
        begin
            must_be_one <= w_q[txc_pkg::MBO_BIT];
            tx_fifo_size <= w_q[txc_pkg::SIZE_LSB +: txc_pkg::SIZE_W];
        end
    end

    // interrupts: sticky, read clears, set wins
    // a stop requested while already idle completes at once
    assign stopped_evt = stop_tx && halted;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_status <= '0;
            irq_mask <= '0;
            full_q <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            full_q <= sts_full;
            if (do_read && (araddr == txc_pkg::IRQ_STATUS_OFFSET))
                irq_status <= '0;
            if (sts_full && !full_q)
                irq_status[txc_pkg::IRQ_STS_FULL_BIT] <= 1'b1;
            if (stopped_evt)
                irq_status[txc_pkg::IRQ_STOPPED_BIT] <= 1'b1;
            if (do_write && (aw_addr_q == txc_pkg::IRQ_MASK_OFFSET) && ws_q[0])
                irq_mask <= w_q[IRQ_W_L-1:0];
            irq <= |(irq_status & irq_mask);
        end
    end

    // checks
    sequence stop_seen_s;
        stop_tx && halted;
    endsequence

    stop_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        stop_seen_s |=> !stop_tx)
        else $error("stop bit did not clear after halt");
    ena_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        stop_seen_s |=> !tx_on)
        else $error("enable did not clear after halt");
    stop_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        stop_tx && !halted |=> stop_tx)
        else $error("stop bit changed while high");
    full_pause_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_go |-> $past(status_overrun_allow || !sts_full))
        else $error("frame started with full status fifo");
    overrun_go_a: assert property (@(posedge aclk) disable iff (!aresetn)
        frame_start_req && state == TXC_RUN && tx_on && !stop_tx && status_overrun_allow
        |=> tx_go)
        else $error("overrun allowed but no frame start");
    sts_flush_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_status_flush |=> sts_level == '0 && !tx_status_flush)
        else $error("status fifo not flushed");
    dat_flush_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_data_flush |=> dat_level == '0 && !tx_data_flush)
        else $error("data fifo not flushed");
    split_sum_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_b + tx_total == (ADDR_W+1)'(txc_pkg::MEM_BYTES) && dat_bytes + sts_bytes == tx_total)
        else $error("memory split does not add up");
    full_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sts_full && !full_q |=> irq_status[txc_pkg::IRQ_STS_FULL_BIT])
        else $error("status full event lost");
    no_go_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(stop_tx) |-> !tx_go)
        else $error("frame started after stop request");
endmodule : txc_regs

// ==== txc_pkg.sv ====
// txc_pkg: register map, field positions, reset values and sizing constants
package txc_pkg;
    localparam logic [7:0] TXCFG_OFFSET = 8'h70;
    localparam logic [7:0] HWCFG_OFFSET = 8'h74;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h78;
    localparam logic [7:0] IRQ_MASK_OFFSET = 8'h7C;
    localparam int TXS_FLUSH_BIT = 15;
    localparam int TXD_FLUSH_BIT = 14;
    localparam int SOA_BIT = 2;
    localparam int TX_ON_BIT = 1;
    localparam int STOP_TX_BIT = 0;
    localparam int STRAP_BIT = 24;
    localparam int MBO_BIT = 20;
    localparam int SIZE_LSB = 16;
    localparam int SIZE_W = 4;
    localparam logic [3:0] SIZE_RESET = 4'h5;
    localparam logic [3:0] SIZE_MAX = 4'hE;
    localparam logic [3:0] SIZE_MIN = 4'h2;
    localparam int IRQ_STS_FULL_BIT = 0;
    localparam int IRQ_STOPPED_BIT = 1;
    localparam int IRQ_W = 2;
    localparam int MEM_BYTES = 16384;
    localparam int KB_BYTES = 1024;
    localparam int STATUS_FIFO_BYTES = 512;
    localparam int ADDR_W = 14;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : txc_pkg

// ==== txc_ptr.sv ====
// txc_ptr: FIFO pointer pair with flush and fill tracking
`timescale 1ns/1ns
module txc_ptr #(
    parameter int W = 14
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic flush,
    input wire logic push,
    input wire logic pop,
    input wire logic [W-1:0] capacity,
    // state
    output logic [W-1:0] level,
    output logic full,
    output logic empty
);
    logic [W-1:0] wr_ptr;
    logic [W-1:0] rd_ptr;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || flush)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (push && !full)
                wr_ptr <= wr_ptr + W'(1);
            if (pop && !empty)
                rd_ptr <= rd_ptr + W'(1);
        end
    end

    assign level = wr_ptr - rd_ptr;
    assign full = (level >= capacity);
    assign empty = (level == '0);
endmodule : txc_ptr

// ==== txc_alloc.sv ====
// txc_alloc: splits packet memory into transmit and receive regions
`timescale 1ns/1ns
module txc_alloc #(
    parameter int W = 14
) (
    // programmed size in 1KB steps
    input wire logic [3:0] size_kb,
    // region sizes in bytes
    output logic [W:0] tx_total,
    output logic [W:0] tx_status_bytes,
    output logic [W:0] tx_data_bytes,
    output logic [W:0] rx_bytes
);
    logic [3:0] clamped;

    // sizes above the top step are held at the top step
    assign clamped = (size_kb > txc_pkg::SIZE_MAX) ? txc_pkg::SIZE_MAX : size_kb;
    assign tx_total = (W+1)'(int'(clamped) * txc_pkg::KB_BYTES);
    assign tx_status_bytes = (W+1)'(txc_pkg::STATUS_FIFO_BYTES);
    assign tx_data_bytes = tx_total - tx_status_bytes;
    assign rx_bytes = (W+1)'(txc_pkg::MEM_BYTES) - tx_total;
endmodule : txc_alloc

// ==== tb_tx_config_fifo_allocation.sv ====
// self-checking testbench for the transmit configuration and allocation registers
`timescale 1ns/1ns
`define CHK(nm, ex, got) compare(nm, 34'(ex), 34'(got))
module tb_tx_config_fifo_allocation;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, tx_go, tx_running, tx_status_full;
    logic must_be_one_out, irq;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp;
    logic auto_crossover_strap = 1'b1, frame_active = 1'b0, frame_start_req = 1'b0;
    logic status_push = 1'b0, status_pop = 1'b0, data_push = 1'b0, data_pop = 1'b0;
    logic [14:0] tx_data_bytes, rx_bytes;
    logic [1:0] wq[$];
    logic [33:0] rq[$];
    int n_mismatch = 0;
    int check_count = 0;
    logic seen;
    logic [3:0] sz;
    logic [3:0] sizes[5] = '{4'h2, 4'h5, 4'h9, 4'hE, 4'hF};

    txc_regs dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .auto_crossover_strap(auto_crossover_strap),
        .frame_active(frame_active), .frame_start_req(frame_start_req),
        .status_push(status_push), .status_pop(status_pop), .data_push(data_push),
        .data_pop(data_pop), .tx_go(tx_go), .tx_running(tx_running),
        .tx_status_full(tx_status_full), .tx_data_bytes(tx_data_bytes),
        .rx_bytes(rx_bytes), .must_be_one_out(must_be_one_out), .irq(irq));

    always #2 aclk = ~aclk;

    task automatic compare(input string nm, input logic [33:0] ex, input logic [33:0] got);
        check_count++;
        if (got !== ex)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", nm, ex, got);
        end
    endtask : compare

    task automatic close_out;
        $display("checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out

    // responses are matched in order against the notes left by the bus tasks
    always @(posedge aclk)
    begin
        if (bvalid === 1'b1 && bready === 1'b1)
        begin
            if (wq.size() == 0)
                `CHK("stray bresp", 2'b11, bresp);
            else
                `CHK("bresp", wq.pop_front(), bresp);
        end
        if (rvalid === 1'b1 && rready === 1'b1)
        begin
            if (rq.size() == 0)
                `CHK("stray read", 34'h3_FFFF_FFFF, {rresp, rdata});
            else
                `CHK("read", rq.pop_front(), {rresp, rdata});
        end
    end

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit aw_p;
        bit w_p;
        bit b_p;
        aw_p = 1;
        w_p = 1;
        b_p = 1;
        wq.push_back(er);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 200 && b_p; i++)
        begin
            @(posedge aclk);
            if (aw_p && awready === 1'b1)
            begin
                awvalid <= 1'b0;
                aw_p = 0;
            end
            if (w_p && wready === 1'b1)
            begin
                wvalid <= 1'b0;
                w_p = 0;
            end
            if (b_p && bvalid === 1'b1)
            begin
                bready <= 1'b0;
                b_p = 0;
            end
        end
        if (b_p)
            `CHK("write answer", 1'b1, 1'b0);
        @(posedge aclk);
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
        bit a_p;
        bit r_p;
        a_p = 1;
        r_p = 1;
        rq.push_back({er, ex});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 200 && r_p; i++)
        begin
            @(posedge aclk);
            if (a_p && arready === 1'b1)
            begin
                arvalid <= 1'b0;
                a_p = 0;
            end
            if (r_p && rvalid === 1'b1)
            begin
                rready <= 1'b0;
                r_p = 0;
            end
        end
        if (r_p)
            `CHK("read answer", 1'b1, 1'b0);
        @(posedge aclk);
    endtask : axi_read

    // asks for a frame and notes whether permission came within a few cycles
    task automatic go_seen(output logic s);
        s = 1'b0;
        frame_start_req <= 1'b1;
        repeat (6)
        begin
            @(posedge aclk);
            if (tx_go === 1'b1)
                s = 1'b1;
        end
        frame_start_req <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask : go_seen

    // one status word per cycle until the 512-byte status region holds 128 words
    task automatic fill_status;
        status_push <= 1'b1;
        repeat (128) @(posedge aclk);
        status_push <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask : fill_status

    initial
    begin
        #60000;
        `CHK("watchdog", 1'b0, 1'b1);
        close_out();
    end

    initial
    begin
        void'($urandom(14771));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        auto_crossover_strap <= 1'b0;
        `CHK("tx_data_bytes", 15'd4608, tx_data_bytes);
        `CHK("rx_bytes", 15'd11264, rx_bytes);
        axi_read(txc_pkg::TXCFG_OFFSET, 32'h0000_0000, txc_pkg::RESP_OKAY);
        axi_read(txc_pkg::HWCFG_OFFSET, 32'h0105_0000, txc_pkg::RESP_OKAY);
        $display("test reset values done");
        // configuration written only while transmitter is off
        for (int i = 0; i < 5; i++)
        begin
            axi_write(txc_pkg::HWCFG_OFFSET, ($urandom() & 32'hFEE0_FFFF)
                | 32'h0010_0000 | (32'(sizes[i]) << 16), txc_pkg::RESP_OKAY);
            sz = (sizes[i] > 4'hE) ? 4'hE : sizes[i];
            axi_read(txc_pkg::HWCFG_OFFSET, 32'h0110_0000
                | (32'(sizes[i]) << 16), txc_pkg::RESP_OKAY);
            `CHK("must_be_one_out", 1'b1, must_be_one_out);
            `CHK("tx_data_bytes", 15'(sz * 1024 - 512), tx_data_bytes);
            `CHK("rx_bytes", 15'(16384 - sz * 1024), rx_bytes);
        end
        $display("test allocation done");
        axi_write(8'h80, 32'hFFFF_FFFF, txc_pkg::RESP_SLVERR);
        axi_read(8'h40, 32'h0000_0000, txc_pkg::RESP_SLVERR);
        axi_write(txc_pkg::IRQ_MASK_OFFSET, 32'h0000_0003, txc_pkg::RESP_OKAY);
        axi_read(txc_pkg::IRQ_MASK_OFFSET, 32'h0000_0003, txc_pkg::RESP_OKAY);
        axi_read(txc_pkg::IRQ_STATUS_OFFSET, 32'h0000_0000, txc_pkg::RESP_OKAY);
        $display("test map and mask done");
        axi_write(txc_pkg::TXCFG_OFFSET, ($urandom() & 32'hFFFF_3FF8) | 32'h2, txc_pkg::RESP_OKAY);
        axi_read(txc_pkg::TXCFG_OFFSET, 32'h0000_0002, txc_pkg::RESP_OKAY);
        `CHK("tx_running", 1'b1, tx_running);
        go_seen(seen);
        `CHK("go enabled", 1'b1, seen);
        fill_status();
        `CHK("tx_status_full", 1'b1, tx_status_full);
        go_seen(seen);
        `CHK("go while full", 1'b0, seen);
        `CHK("irq", 1'b1, irq);
        axi_read(txc_pkg::IRQ_STATUS_OFFSET, 32'h0000_0001, txc_pkg::RESP_OKAY);
        repeat (2) @(posedge aclk);
        `CHK("irq cleared", 1'b0, irq);
        axi_write(txc_pkg::TXCFG_OFFSET, 32'h0000_0006, txc_pkg::RESP_OKAY);
        go_seen(seen);
        `CHK("go overrun", 1'b1, seen);
        axi_write(txc_pkg::TXCFG_OFFSET, 32'h0000_8006, txc_pkg::RESP_OKAY);
        repeat (3) @(posedge aclk);
        `CHK("full after flush", 1'b0, tx_status_full);
        axi_read(txc_pkg::TXCFG_OFFSET, 32'h0000_0006, txc_pkg::RESP_OKAY);
        fill_status();
        axi_read(txc_pkg::IRQ_STATUS_OFFSET, 32'h0000_0001, txc_pkg::RESP_OKAY);
        data_push <= 1'b1;
        repeat (20) @(posedge aclk);
        data_push <= 1'b0;
        data_pop <= 1'b1;
        status_pop <= 1'b1;
        @(posedge aclk);
        data_pop <= 1'b0;
        status_pop <= 1'b0;
        axi_write(txc_pkg::TXCFG_OFFSET, 32'h0000_C006, txc_pkg::RESP_OKAY);
        axi_read(txc_pkg::TXCFG_OFFSET, 32'h0000_0006, txc_pkg::RESP_OKAY);
        $display("test status fifo done");
        frame_active <= 1'b1;
        axi_write(txc_pkg::TXCFG_OFFSET, 32'h0000_0007, txc_pkg::RESP_OKAY);
        axi_read(txc_pkg::TXCFG_OFFSET, 32'h0000_0007, txc_pkg::RESP_OKAY);
        axi_write(txc_pkg::TXCFG_OFFSET, 32'h0000_0006, txc_pkg::RESP_OKAY);
        axi_read(txc_pkg::TXCFG_OFFSET, 32'h0000_0007, txc_pkg::RESP_OKAY);
        `CHK("running mid frame", 1'b1, tx_running);
        frame_active <= 1'b0;
        repeat (4) @(posedge aclk);
        axi_read(txc_pkg::TXCFG_OFFSET, 32'h0000_0004, txc_pkg::RESP_OKAY);
        `CHK("tx_running", 1'b0, tx_running);
        go_seen(seen);
        `CHK("go after stop", 1'b0, seen);
        axi_read(txc_pkg::IRQ_STATUS_OFFSET, 32'h0000_0002, txc_pkg::RESP_OKAY);
        $display("test stop done");
        repeat (4) @(posedge aclk);
        close_out();
    end
endmodule : tb_tx_config_fifo_allocation
